/* logic/cfl_fault_logger.sv */
// Function
// - critical fault disables supplies, starts logging
// - only enabled threshold violations trigger logging
// - record written to locations 01h..0Eh
// - after log, lock blocks new records
// - write one to unlock bit releases lock
// - content select picks flags, values, both, none
// - stored conversion values truncated to eight bits
// - channel flags set on over/undervoltage
// - 48h bits enable undervoltage, channels 1-8
// - 49h undervoltage 9-12, overvoltage 1-4
// - flag cleared by writing one, zero ignored
// - flag set only when its enable set
// - evaluate at conversion end, upper eight bits
`default_nettype none
module cfl_fault_logger
#(
    parameter int unsigned NUM_CH = cfl_pkg::NUM_CH
)
(
    // clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              sys_rst_in,
    // conversion results from the monitoring path
    input  wire logic              conv_done_in,
    input  wire cfl_pkg::cfl_conv_t conv_in,
    input  wire cfl_pkg::cfl_thr_t thr_in,
    // register access port
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    input  wire logic              reg_ext_in,
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    output logic [7:0]             reg_rdata_out,
    output logic                   reg_rvalid_out,
    // supply enables
    input  wire logic [NUM_CH-1:0] supply_en_in,
    output logic [NUM_CH-1:0]      supply_en_out,
    output logic                   shutdown_out,
    // nonvolatile log memory
    output cfl_pkg::cfl_nv_t       nv_out,
    input  wire logic              nv_ack_in,
    output logic                   log_locked_out
);
    typedef enum logic [0:0] {ST_IDLE, ST_WRITE} cfl_state_t;

    cfl_state_t        state;
    logic [7:0]        log_ctrl;
    logic [7:0]        uv_en_lo;
    logic [7:0]        uv_ov_en;
    logic [7:0]        ov_en_hi;
    logic [7:0]        ew_en_lo;
    logic [7:0]        ew_en_hi;
    logic [11:0]       flags;
    logic [7:0]        results [NUM_CH];
    logic [7:0]        snap_res [NUM_CH];
    logic [11:0]       snap_flags;
    logic [1:0]        snap_mode;
    logic              locked;
    logic [11:0]       en_uv;
    logic [11:0]       en_ov;
    logic [11:0]       en_ew;
    logic              ov_hit;
    logic              uv_hit;
    logic              ew_hit;
    logic              ch_ok;
    logic [11:0]       ch_sel;
    logic [11:0]       flag_set;
    logic [11:0]       flag_clr;
    logic [11:0]       next_flags;
    logic              crit_evt;
    logic              log_start;
    logic              log_end;
    logic              unlock_wr;
    logic [3:0]        next_addr;

    function automatic logic main_hit(input logic [7:0] a);
        main_hit = reg_wr_in && !reg_ext_in && (reg_addr_in == a);
    endfunction : main_hit

    function automatic logic [3:0] first_addr(input logic [1:0] m);
        first_addr = (m == cfl_pkg::LOG_CONV) ? cfl_pkg::NV_CONV_0
                                              : cfl_pkg::NV_FLAG_LO;
    endfunction : first_addr

    cfl_threshold_cmp i_cfl_threshold_cmp
    (
        .conv_in (conv_in.data),
        .thr_in  (thr_in),
        .ov_out  (ov_hit),
        .uv_out  (uv_hit),
        .ew_out  (ew_hit)
    );

    ////////////////////////////////////////////////////////////////////
    // enable mapping and fault detection
    assign en_uv = {uv_ov_en[3:0], uv_en_lo};
    assign en_ov = {ov_en_hi, uv_ov_en[7:4]};
    assign en_ew = {ew_en_hi[3:0], ew_en_lo};
    assign ch_ok = conv_done_in && (conv_in.chan < 4'(NUM_CH));
    assign ch_sel = ch_ok ? (12'h001 << conv_in.chan) : 12'h000;
    assign flag_set = ch_sel & ((en_uv & {12{uv_hit}}) |
                                (en_ov & {12{ov_hit}}));
    assign crit_evt = |(ch_sel & ((en_uv & {12{uv_hit}}) |
                                  (en_ov & {12{ov_hit}}) |
                                  (en_ew & {12{ew_hit}})));
    assign flag_clr = {reg_wdata_in[3:0] &
                       {4{reg_wr_in && reg_ext_in &&
                          reg_addr_in == cfl_pkg::OFF_FLAG_HI}},
                       reg_wdata_in &
                       {8{reg_wr_in && reg_ext_in &&
                          reg_addr_in == cfl_pkg::OFF_FLAG_LO}}};
    assign next_flags = (flags & ~flag_clr) | flag_set;
    assign unlock_wr = main_hit(cfl_pkg::OFF_LOG_LOCK) &&
                       reg_wdata_in[cfl_pkg::UNLOCK_BIT];
    assign log_start = crit_evt && (state == ST_IDLE) && !locked &&
                       (log_ctrl[1:0] != cfl_pkg::LOG_OFF);
    assign log_end = (state == ST_WRITE) && nv_ack_in &&
                     ((nv_out.addr == cfl_pkg::NV_LAST) ||
                      (snap_mode == cfl_pkg::LOG_FLAGS &&
                       nv_out.addr == cfl_pkg::NV_FLAG_HI));
    assign next_addr = (snap_mode == cfl_pkg::LOG_BOTH &&
                        nv_out.addr == cfl_pkg::NV_FLAG_HI)
                       ? cfl_pkg::NV_CONV_0 : nv_out.addr + 4'h1;

    ////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            log_ctrl <= cfl_pkg::REG_RST;
            uv_en_lo <= cfl_pkg::REG_RST;
            uv_ov_en <= cfl_pkg::REG_RST;
            ov_en_hi <= cfl_pkg::REG_RST;
            ew_en_lo <= cfl_pkg::REG_RST;
            ew_en_hi <= cfl_pkg::REG_RST;
        end
        else
        begin
            if (main_hit(cfl_pkg::OFF_LOG_CTRL))
                log_ctrl <= {6'h00, reg_wdata_in[1:0]};
            if (main_hit(cfl_pkg::OFF_UV_EN_LO))
                uv_en_lo <= reg_wdata_in;
            if (main_hit(cfl_pkg::OFF_UV_OV_EN))
                uv_ov_en <= reg_wdata_in;
            if (main_hit(cfl_pkg::OFF_OV_EN_HI))
                ov_en_hi <= reg_wdata_in;
            if (main_hit(cfl_pkg::OFF_EW_EN_LO))
                ew_en_lo <= reg_wdata_in;
            if (main_hit(cfl_pkg::OFF_EW_EN_HI))
                ew_en_hi <= {4'h0, reg_wdata_in[3:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // fault flags and conversion results
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            flags <= cfl_pkg::FLAG_RST;
        else
            flags <= next_flags;
    end

    generate
        for (genvar i = 0; i < NUM_CH; i++)
        begin : g_res
            always_ff @(posedge clk_sys_in)
            begin
                if (sys_rst_in)
                    results[i] <= 8'h00;
                else if (ch_sel[i])
                    results[i] <= conv_in.data[9:2];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // register read
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            reg_rdata_out  <= 8'h00;
            if (reg_rd_in && reg_ext_in)
            begin
                case (reg_addr_in)
                    cfl_pkg::OFF_FLAG_LO: reg_rdata_out <= flags[7:0];
                    cfl_pkg::OFF_FLAG_HI: reg_rdata_out <= {4'h0, flags[11:8]};
                    default:              reg_rdata_out <= 8'h00;
                endcase
            end
            else if (reg_rd_in)
            begin
                case (reg_addr_in)
                    cfl_pkg::OFF_LOG_CTRL: reg_rdata_out <= log_ctrl;
                    cfl_pkg::OFF_UV_EN_LO: reg_rdata_out <= uv_en_lo;
                    cfl_pkg::OFF_UV_OV_EN: reg_rdata_out <= uv_ov_en;
                    cfl_pkg::OFF_OV_EN_HI: reg_rdata_out <= ov_en_hi;
                    cfl_pkg::OFF_EW_EN_LO: reg_rdata_out <= ew_en_lo;
                    cfl_pkg::OFF_EW_EN_HI: reg_rdata_out <= ew_en_hi;
                    cfl_pkg::OFF_LOG_LOCK:
                        reg_rdata_out <= {6'h00, locked, 1'b0};
                    default:               reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // supply shutdown
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            shutdown_out  <= 1'b0;
            supply_en_out <= '0;
        end
        else
        begin
            if (crit_evt)
                shutdown_out <= 1'b1;
            supply_en_out <= (crit_evt || shutdown_out) ? '0 : supply_en_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // log lock, set wins over unlock
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            locked <= 1'b0;
        else if (log_end)
            locked <= 1'b1;
        else if (unlock_wr)
            locked <= 1'b0;
    end
    assign log_locked_out = locked;

    ////////////////////////////////////////////////////////////////////
    // record writer
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            state      <= ST_IDLE;
            nv_out     <= '0;
            snap_flags <= cfl_pkg::FLAG_RST;
            snap_mode  <= cfl_pkg::LOG_BOTH;
            for (int i = 0; i < NUM_CH; i++)
                snap_res[i] <= 8'h00;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (log_start)
                    begin
                        state      <= ST_WRITE;
                        snap_flags <= next_flags;
                        snap_mode  <= log_ctrl[1:0];
                        for (int i = 0; i < NUM_CH; i++)
                            snap_res[i] <= ch_sel[i] ? conv_in.data[9:2]
                                                     : results[i];
                        nv_out.we   <= 1'b1;
                        nv_out.addr <= first_addr(log_ctrl[1:0]);
                        nv_out.data <= (log_ctrl[1:0] == cfl_pkg::LOG_CONV)
                                       ? (ch_sel[0] ? conv_in.data[9:2]
                                                    : results[0])
                                       : next_flags[7:0];
                    end
                end
                ST_WRITE:
                begin
                    if (log_end)
                    begin
                        state     <= ST_IDLE;
                        nv_out.we <= 1'b0;
                    end
                    else if (nv_ack_in)
                    begin
                        nv_out.addr <= next_addr;
                        if (next_addr == cfl_pkg::NV_FLAG_HI)
                            nv_out.data <= {4'h0, snap_flags[11:8]};
                        else
                            nv_out.data <= snap_res[4'(next_addr -
                                                    cfl_pkg::NV_CONV_0)];
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    property p_shutdown;
        crit_evt |=> (supply_en_out == '0) && shutdown_out;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("supplies not off after critical fault");

    property p_gated;
        $rose(shutdown_out) |-> $past(crit_evt);
    endproperty
    a_gated: assert property (p_gated)
        else $error("shutdown without enabled fault");

    property p_range;
        nv_out.we |-> (nv_out.addr >= cfl_pkg::NV_FLAG_LO) &&
                      (nv_out.addr <= cfl_pkg::NV_LAST);
    endproperty
    a_range: assert property (p_range)
        else $error("log address out of record");

    property p_lock;
        (locked && state == ST_IDLE) |=> !nv_out.we;
    endproperty
    a_lock: assert property (p_lock)
        else $error("record written while locked");

    property p_unlock;
        (unlock_wr && !log_end) |=> !locked;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock write ignored");

    property p_off;
        (crit_evt && log_ctrl[1:0] == cfl_pkg::LOG_OFF && state == ST_IDLE)
            |=> state == ST_IDLE;
    endproperty
    a_off: assert property (p_off)
        else $error("logging while disabled");

    property p_flags_only;
        (nv_out.we && snap_mode == cfl_pkg::LOG_FLAGS)
            |-> nv_out.addr <= cfl_pkg::NV_FLAG_HI;
    endproperty
    a_flags_only: assert property (p_flags_only)
        else $error("conversion stored in flags-only mode");

    property p_trunc;
        ch_ok |=> results[$past(conv_in.chan)] == $past(conv_in.data[9:2]);
    endproperty
    a_trunc: assert property (p_trunc)
        else $error("stored result not upper eight bits");

    property p_w0;
        (flag_set == 12'h000) |=> (flags & ~$past(flags)) == 12'h000;
    endproperty
    a_w0: assert property (p_w0)
        else $error("flag set without enabled fault");

    property p_w1c;
        (reg_wr_in && reg_ext_in && reg_addr_in == cfl_pkg::OFF_FLAG_LO &&
         reg_wdata_in == 8'h00) |=> flags[7:0] >= $past(flags[7:0]);
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("zero write cleared a flag");

    property p_ov4;
        (ch_ok && conv_in.chan == 4'h3 && ov_hit && uv_ov_en[7])
            |=> shutdown_out ##0 flags[3];
    endproperty
    a_ov4: assert property (p_ov4)
        else $error("channel 4 overvoltage not acted on");

    c_log_done: cover property (log_end && snap_mode == cfl_pkg::LOG_BOTH);
    c_flags:    cover property (log_end && snap_mode == cfl_pkg::LOG_FLAGS);
    c_unlock:   cover property (locked ##1 unlock_wr ##1 !locked);
    c_relog:    cover property (unlock_wr ##[1:50] log_start);
endmodule : cfl_fault_logger
`default_nettype wire

/* logic/cfl_pkg.sv */
`default_nettype none
package cfl_pkg;
    localparam int unsigned NUM_CH = 12;
    // register offsets, main page
    localparam logic [7:0] OFF_LOG_CTRL = 8'h47;
    localparam logic [7:0] OFF_UV_EN_LO = 8'h48;
    localparam logic [7:0] OFF_UV_OV_EN = 8'h49;
    localparam logic [7:0] OFF_OV_EN_HI = 8'h4a;
    localparam logic [7:0] OFF_EW_EN_LO = 8'h4b;
    localparam logic [7:0] OFF_EW_EN_HI = 8'h4c;
    localparam logic [7:0] OFF_LOG_LOCK = 8'h5d;
    // register offsets, extended page
    localparam logic [7:0] OFF_FLAG_LO  = 8'h18;
    localparam logic [7:0] OFF_FLAG_HI  = 8'h19;
    // field positions and reset values
    localparam int unsigned UNLOCK_BIT   = 1;
    localparam logic [7:0]  REG_RST      = 8'h00;
    localparam logic [11:0] FLAG_RST     = 12'h000;
    // log content select encodings
    localparam logic [1:0] LOG_BOTH  = 2'h0;
    localparam logic [1:0] LOG_FLAGS = 2'h1;
    localparam logic [1:0] LOG_CONV  = 2'h2;
    localparam logic [1:0] LOG_OFF   = 2'h3;
    // nonvolatile record layout
    localparam logic [3:0] NV_FLAG_LO = 4'h1;
    localparam logic [3:0] NV_FLAG_HI = 4'h2;
    localparam logic [3:0] NV_CONV_0  = 4'h3;
    localparam logic [3:0] NV_LAST    = 4'he;

    typedef struct packed {
        logic [3:0] chan;
        logic [9:0] data;
    } cfl_conv_t;

    typedef struct packed {
        logic [7:0] ov_thr;
        logic [7:0] uv_thr;
        logic [7:0] ew_thr;
        logic       ew_is_ov;
    } cfl_thr_t;

    typedef struct packed {
        logic       we;
        logic [3:0] addr;
        logic [7:0] data;
    } cfl_nv_t;
endpackage : cfl_pkg
`default_nettype wire

/* logic/cfl_threshold_cmp.sv */
`default_nettype none
module cfl_threshold_cmp
(
    // conversion and limits
    input  wire logic [9:0] conv_in,
    input  wire cfl_pkg::cfl_thr_t thr_in,
    // comparison results
    output logic            ov_out,
    output logic            uv_out,
    output logic            ew_out
);
    logic [7:0] top8;

    // only the upper eight bits meet the limits
    assign top8   = conv_in[9:2];
    assign ov_out = top8 > thr_in.ov_thr;
    assign uv_out = top8 < thr_in.uv_thr;
    assign ew_out = thr_in.ew_is_ov ? (top8 > thr_in.ew_thr)
                                    : (top8 < thr_in.ew_thr);
endmodule : cfl_threshold_cmp
`default_nettype wire

/* tb/cfl_fault_logger_tb.sv */
`default_nettype none
module cfl_fault_logger_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("wrong value %s exp %h got %h", what, exp, got); \
        end \
    end
    logic               clk_sys_in, sys_rst_in, conv_done_in;
    cfl_pkg::cfl_conv_t conv_in;
    cfl_pkg::cfl_thr_t  thr_in, t;
    logic               reg_wr_in, reg_rd_in, reg_ext_in, wipe;
    logic [7:0]         reg_addr_in, reg_wdata_in, reg_rdata_out, v;
    logic               reg_rvalid_out, shutdown_out, log_locked_out;
    logic [11:0]        supply_en_in, supply_en_out, fl;
    cfl_pkg::cfl_nv_t   nv_out;
    logic               nv_ack_in;
    logic [1:0]         dly, ex;
    logic [15:0][7:0]   mem;
    logic [15:0]        wr_mask, mask;
    logic [9:0]         d;
    logic [3:0]         ch;
    logic [7:0]         en [5];
    logic [7:0]         res [12];
    int                 n_fail, samples_checked, seed;
    logic [8:0]         rst_list [10] = '{9'h047, 9'h048, 9'h049, 9'h04a,
        9'h04b, 9'h04c, 9'h05d, 9'h050, 9'h118, 9'h119};

    cfl_fault_logger i_cfl_fault_logger (.clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in), .conv_done_in(conv_done_in),
        .conv_in(conv_in), .thr_in(thr_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_ext_in(reg_ext_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
        .supply_en_in(supply_en_in), .supply_en_out(supply_en_out),
        .shutdown_out(shutdown_out), .nv_out(nv_out),
        .nv_ack_in(nv_ack_in), .log_locked_out(log_locked_out));
    cfl_nv_model i_cfl_nv_model (.clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in), .nv_in(nv_out), .nv_ack_out(nv_ack_in),
        .dly_in(dly), .wipe_in(wipe), .mem_out(mem),
        .wr_mask_out(wr_mask));
    ////////////////////////////////////////////////////////////
    // bus cycles and stimulus
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk_sys_in);
    endtask : tick

    task automatic wr(logic ext, logic [7:0] a, logic [7:0] dat);
        reg_ext_in <= ext;
        reg_addr_in <= a;
        reg_wdata_in <= dat;
        reg_wr_in <= 1'b1;
        tick();
        reg_wr_in <= 1'b0;
        tick();
    endtask : wr

    task automatic rd(logic ext, logic [7:0] a, logic [7:0] exp);
        reg_ext_in <= ext;
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        tick();
        reg_rd_in <= 1'b0;
        @(negedge clk_sys_in);
        `CHK("rvalid", 1'b1, reg_rvalid_out)
        `CHK("rdata", exp, reg_rdata_out)
        tick();
    endtask : rd

    task automatic conv(logic [3:0] c, logic [9:0] dat);
        conv_in <= '{chan: c, data: dat};
        thr_in <= t;
        conv_done_in <= 1'b1;
        tick();
        conv_done_in <= 1'b0;
        conv_in <= 14'($random(seed));
        thr_in <= 25'($random(seed));
        tick();
    endtask : conv

    task automatic do_reset();
        sys_rst_in <= 1'b1;
        tick(2);
        sys_rst_in <= 1'b0;
        tick();
    endtask : do_reset

    task automatic wait_lock(logic [15:0] m);
        int n;
        n = 0;
        while (log_locked_out !== 1'b1 && n < 200)
        begin
            tick();
            n++;
        end
        `CHK("locked", 1'b1, log_locked_out)
        `CHK("record mask", m, wr_mask)
    endtask : wait_lock

    task automatic clear_record();
        wipe <= 1'b1;
        tick();
        wipe <= 1'b0;
        tick();
    endtask : clear_record

    // bit0 flag expected, bit1 critical expected
    function automatic logic [1:0] judge(logic [3:0] c, logic [7:0] d8);
        logic [11:0] uv_en, ov_en, ew_en;
        logic        ew;
        uv_en = {en[1][3:0], en[0]};
        ov_en = {en[2], en[1][7:4]};
        ew_en = {en[4][3:0], en[3]};
        ew = t.ew_is_ov ? d8 > t.ew_thr : d8 < t.ew_thr;
        judge[0] = (d8 < t.uv_thr && uv_en[c]) || (d8 > t.ov_thr && ov_en[c]);
        judge[1] = judge[0] || (ew && ew_en[c]);
    endfunction : judge

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////
    // clock, watchdog and test sequence
    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    initial
    begin
        tick(20000);
        n_fail++;
        summarize();
    end

    initial
    begin
        seed = 6;
        {conv_done_in, reg_wr_in, reg_rd_in, reg_ext_in} = 4'h0;
        {reg_addr_in, reg_wdata_in, conv_in, thr_in, t} = '0;
        supply_en_in = 12'hfff;
        dly = 2'h0;
        wipe = 1'b1;
        do_reset();
        wipe <= 1'b0;
        foreach (rst_list[i])
            rd(rst_list[i][8], rst_list[i][7:0], 8'h00);
        for (int a = 0; a < 6; a++)
        begin
            v = 8'($random(seed));
            wr(1'b0, 8'h47 + 8'(a), v);
            rd(1'b0, 8'h47 + 8'(a),
               a == 0 ? v & 8'h03 : a == 5 ? v & 8'h0f : v);
        end
        $display("test registers done");
        repeat (40)
        begin
            do_reset();
            foreach (en[i])
            begin
                en[i] = 8'($random(seed));
                wr(1'b0, 8'h48 + 8'(i), en[i]);
            end
            en[4][7:4] = 4'h0;
            wr(1'b0, 8'h47, 8'h03);
            ch = 4'({$random(seed)} % 12);
            d = 10'($random(seed));
            t = 25'($random(seed));
            t.ov_thr = d[9:2] + 8'($random(seed) % 2);
            t.uv_thr = d[9:2] + 8'($random(seed) % 2);
            ex = judge(ch, d[9:2]);
            supply_en_in <= 12'($random(seed));
            conv(ch, d);
            `CHK("shutdown", ex[1], shutdown_out)
            `CHK("supply", ex[1] ? 12'h000 : supply_en_in, supply_en_out)
            fl = 12'(ex[0]) << ch;
            rd(1'b1, 8'h18, fl[7:0]);
            rd(1'b1, 8'h19, {4'h0, fl[11:8]});
            wr(1'b1, 8'h18, 8'h00);
            wr(1'b1, 8'h19, 8'h00);
            rd(1'b1, 8'h18, fl[7:0]);
            wr(1'b1, 8'h18, 8'hff);
            wr(1'b1, 8'h19, 8'hff);
            rd(1'b1, 8'h19, 8'h00);
            `CHK("no record", 16'h0000, wr_mask)
        end
        $display("test gating done");
        for (int m = 0; m < 3; m++)
        begin
            do_reset();
            dly <= 2'(m);
            wr(1'b0, 8'h47, 8'(m));
            wr(1'b0, 8'h48, 8'hff);
            wr(1'b0, 8'h49, 8'h0f);
            t = '{ov_thr: 8'hff, uv_thr: 8'h00, ew_thr: 8'h00, ew_is_ov: 1'b0};
            for (int c = 0; c < 12; c++)
            begin
                d = 10'($random(seed));
                res[c] = d[9:2];
                conv(4'(c), d);
            end
            t.uv_thr = 8'hff;
            ch = 4'({$random(seed)} % 12);
            d = 10'($random(seed)) & 10'h1ff;
            res[ch] = d[9:2];
            conv(ch, d);
            fl = 12'h001 << ch;
            mask = m == 0 ? 16'h7ffe : m == 1 ? 16'h0006 : 16'h7ff8;
            wait_lock(mask);
            if (m != 2)
                `CHK("flag record", {4'h0, fl}, {mem[2], mem[1]})
            for (int c = 0; c < 12 && m != 1; c++)
                `CHK("result record", res[c], mem[3 + c])
            rd(1'b0, 8'h5d, 8'h02);
            clear_record();
            conv(ch, d);
            tick(30);
            `CHK("locked record", 16'h0000, wr_mask)
            wr(1'b0, 8'h5d, 8'h02);
            rd(1'b0, 8'h5d, 8'h00);
            conv(ch, d);
            wait_lock(mask);
        end
        $display("test record done");
        summarize();
    end
endmodule : cfl_fault_logger_tb
`default_nettype wire

/* tb/cfl_nv_model.sv */
`default_nettype none
module cfl_nv_model
(
    // clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             sys_rst_in,
    // log write port
    input  wire cfl_pkg::cfl_nv_t nv_in,
    output logic                  nv_ack_out,
    // stall length and record view
    input  wire logic [1:0]       dly_in,
    input  wire logic             wipe_in,
    output logic [15:0][7:0]      mem_out,
    output logic [15:0]           wr_mask_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;
    ////////////////////////////////////////////////////////////
    // acknowledge after dly_in stall cycles
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || nv_ack_out || !nv_in.we)
        begin
            nv_ack_out <= 1'b0;
            cnt        <= 2'h0;
        end
        else if (cnt == dly_in)
            nv_ack_out <= 1'b1;
        else
            cnt <= cnt + 2'h1;
    end
    ////////////////////////////////////////////////////////////
    // store a byte when the handshake completes
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || wipe_in)
            wr_mask_out <= 16'h0000;
        else if (nv_ack_out && nv_in.we)
        begin
            mem_out[nv_in.addr]     <= nv_in.data;
            wr_mask_out[nv_in.addr] <= 1'b1;
        end
    end
endmodule : cfl_nv_model
`default_nettype wire
